//--- src/lintc_core.sv
// lin transceiver mode control, top level
// assumes pin levels are already synchronous logic; analog sensed outside
`timescale 1ns/100ps
module lintc_core import lintc_pkg::*; #(
    parameter int DOM_CYC = DOM_TIMEOUT_CYC,
    parameter int REARM = REARM_CYC,
    parameter int WAKE_CYC = WAKE_FILT_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // microcontroller side
    input wire logic mode_sel,
    input wire logic txd_in,
    output logic txd_out,
    output logic txd_oe,
    output logic rxd,
    input wire logic local_wake_input,
    // bus side
    input wire logic bus_in,
    output logic bus_drive_low,
    // analog monitors
    input wire logic battery_uv_tx,
    input wire logic battery_uv_fs,
    input wire logic vcc_uv,
    input wire logic driver_shutdown_temperature,
    // status
    output logic internal_reset_n,
    output logic regulator_en,
    output logic [1:0] mode
);
    // ************************************************************
    // reset release
    // ************************************************************
    logic [1:0] rsync_r;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) rsync_r <= 2'b00;
        else rsync_r <= {rsync_r[0], 1'b1};
    end
    wire rst_s_n = rsync_r[1];

    // ************************************************************
    // timers
    // ************************************************************
    lintc_tmr_if dom_t ();
    lintc_tmr_if arm_t ();
    lintc_tmr_if wk_t ();
    lintc_timer u_dom (.mclk(mclk), .rst_n(rst_s_n), .ce(ce), .t(dom_t.tmr));
    lintc_timer u_arm (.mclk(mclk), .rst_n(rst_s_n), .ce(ce), .t(arm_t.tmr));
    lintc_timer u_wk (.mclk(mclk), .rst_n(rst_s_n), .ce(ce), .t(wk_t.tmr));

    // ************************************************************
    // state
    // ************************************************************
    lintc_mode_t st_r, st_nxt;
    lintc_src_t src_r, src_nxt;
    logic en_d_r, armed_r, armed_nxt, wk_seen_r, wk_seen_nxt, hot_r;
    logic bus_d_r;

    wire en_fall = en_d_r && !mode_sel;
    wire in_low = (st_r == LINTC_SLEEP) || (st_r == LINTC_SILENT);
    wire vcc_ok = !vcc_uv && (st_r != LINTC_SLEEP);
    // bus wake: dominant held past filter, then a rising edge
    wire bus_wake = in_low && wk_seen_r && bus_in && !bus_d_r;
    wire bus_wake_ok = bus_wake && ((st_r == LINTC_SLEEP) || txd_in);
    wire loc_wake = in_low && !local_wake_input;

    // ************************************************************
    // mode machine
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        src_nxt = src_r;
        unique case (st_r)
            LINTC_FAILSAFE: begin
                if (mode_sel && !battery_uv_fs) begin
                    st_nxt = LINTC_NORMAL;
                    src_nxt = LINTC_SRC_NONE;
                end else if (en_fall && src_r == LINTC_SRC_BATT) begin
                    // real pin level decides
                    st_nxt = txd_in ? LINTC_SILENT : LINTC_SLEEP;
                end
            end
            LINTC_NORMAL: begin
                if (en_fall) begin
                    st_nxt = txd_in ? LINTC_SILENT : LINTC_SLEEP;
                end else if (battery_uv_fs) begin
                    st_nxt = LINTC_FAILSAFE;
                    src_nxt = LINTC_SRC_BATT;
                end
            end
            LINTC_SILENT, LINTC_SLEEP: begin
                if (mode_sel && !battery_uv_fs) begin
                    // mode select high means normal unless battery_uv_fs is set, or vcc_uv in silent
                    st_nxt = LINTC_NORMAL;
                    src_nxt = LINTC_SRC_NONE;
                end else if (bus_wake_ok) begin
                    st_nxt = LINTC_FAILSAFE;
                    src_nxt = LINTC_SRC_BUS;
                end else if (loc_wake) begin
                    st_nxt = LINTC_FAILSAFE;
                    src_nxt = LINTC_SRC_LOCAL;
                end
            end
        endcase
        if (!vcc_ok && st_r != LINTC_SLEEP) begin
            st_nxt = LINTC_FAILSAFE;
        end
    end

    // driver re-arm after normal entry or dominant timeout
    always_comb begin
        armed_nxt = armed_r;
        if (st_r != LINTC_NORMAL) armed_nxt = 1'b0;
        else if (dom_t.done) armed_nxt = 1'b0;
        else if (arm_t.done) armed_nxt = 1'b1;
        if (st_r != LINTC_NORMAL && st_nxt == LINTC_NORMAL && txd_in)
            armed_nxt = 1'b1;
    end

    always_comb begin
        wk_seen_nxt = wk_seen_r;
        if (!in_low || bus_in) wk_seen_nxt = 1'b0;
        if (wk_t.done) wk_seen_nxt = 1'b1;
        if (in_low && bus_in && wk_seen_r) wk_seen_nxt = 1'b0;
    end

    assign dom_t.run = (st_r == LINTC_NORMAL) && !txd_in && armed_r;
    assign dom_t.clr = txd_in;
    assign dom_t.limit = DOM_CYC[21:0];
    assign arm_t.run = (st_r == LINTC_NORMAL) && !armed_r && txd_in;
    assign arm_t.clr = !txd_in;
    assign arm_t.limit = REARM[21:0];
    // wake filter works even with the bus stuck low
    assign wk_t.run = in_low && !bus_in && !wk_seen_r;
    assign wk_t.clr = bus_in;
    assign wk_t.limit = WAKE_CYC[21:0];

    always_ff @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            st_r <= LINTC_FAILSAFE;
            src_r <= LINTC_SRC_NONE;
            en_d_r <= 1'b0;
            armed_r <= 1'b0;
            wk_seen_r <= 1'b0;
            bus_d_r <= 1'b1;
            hot_r <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
            src_r <= src_nxt;
            en_d_r <= mode_sel;
            armed_r <= armed_nxt;
            wk_seen_r <= wk_seen_nxt;
            bus_d_r <= bus_in;
            // comparator carries its own hysteresis
            hot_r <= driver_shutdown_temperature;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    wire drive_nxt = (st_nxt == LINTC_NORMAL) && (st_r == LINTC_NORMAL) &&
                     armed_nxt && !txd_in && !battery_uv_tx &&
                     !driver_shutdown_temperature && !hot_r;
    logic rxd_nxt, txo_nxt, txoe_nxt;
    always_comb begin
        rxd_nxt = 1'b1;
        txo_nxt = 1'b1;
        txoe_nxt = 1'b0;
        unique case (st_nxt)
            LINTC_NORMAL: rxd_nxt = bus_in;
            LINTC_SILENT: rxd_nxt = 1'b1;
            LINTC_SLEEP: rxd_nxt = 1'b0;
            LINTC_FAILSAFE: begin
                txoe_nxt = (src_nxt != LINTC_SRC_NONE);
                unique case (src_nxt)
                    LINTC_SRC_BUS: {txo_nxt, rxd_nxt} = 2'b00;
                    LINTC_SRC_LOCAL: {txo_nxt, rxd_nxt} = 2'b01;
                    LINTC_SRC_BATT: {txo_nxt, rxd_nxt} = 2'b10;
                    LINTC_SRC_NONE: {txo_nxt, rxd_nxt} = {1'b1, bus_in};
                endcase
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            bus_drive_low <= 1'b0;
            rxd <= 1'b1;
            txd_out <= 1'b1;
            txd_oe <= 1'b0;
            internal_reset_n <= 1'b0;
            regulator_en <= 1'b1;
            mode <= 2'b00;
        end else if (ce) begin
            bus_drive_low <= drive_nxt;
            rxd <= rxd_nxt;
            txd_out <= txo_nxt;
            txd_oe <= txoe_nxt;
            // regulator kept alive through thermal shutdown
            regulator_en <= (st_nxt != LINTC_SLEEP);
            internal_reset_n <= !vcc_uv &&
                                (st_nxt != LINTC_SLEEP);
            mode <= st_nxt;
        end
    end
endmodule // lintc_core

//--- src/lintc_pkg.sv
// package of constants for the lin transceiver mode control
// assumes a 125 MHz mclk; analog comparators arrive as clean logic levels
//
// Function
// - mode select high puts the device into normal mode, both paths live, unless battery_uv_fs is set or vcc_uv forces fail-safe
// - battery below about 4.5V blocks bus transmission
// - after battery power-up the device starts in fail-safe mode
// - regulator undervoltage asserts the active-low internal reset
// - valid local wake level wakes the device from sleep or silent
// - driver overheat switches bus output off until cooled by hysteresis
// - regulator stays on while the driver is thermally shut down
// - sleep/silent entry works with bus shorted low; wake once released
// - in normal mode a low transmit level pulls the bus dominant
// - transmit level high or floating keeps the driver off, recessive
// - transmit low at normal entry blocks driver until high over 10us
// - in fail-safe after a wake or battery uv the transmit pin is an output reporting the source
// - transmit low longer than 20ms forces the driver recessive
// - sleep versus silent uses the real transmit pin level
// - after dominant timeout, transmit high over 10us re-arms the driver
// - bus path supports bit rates up to 20 kbaud
// - receive output stays high while the bus is high, except in sleep and the fail-safe bus wake and battery uv codes
// - mode select falling with transmit high enters silent, regulator on
// - mode select falling with transmit low enters sleep, regulator off
// - in normal mode receive mirrors the bus level
// - fail-safe code tx/rx: bus wake 0/0, local wake 0/1, battery uv 1/0
package lintc_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 125;
    localparam int REARM_US = 10;
    localparam int DOM_TIMEOUT_MS = 20;
    localparam int WAKE_FILT_US = 30;
    // least times round up; +1 gives "more than"
    localparam int REARM_CYC = REARM_US * CLK_MHZ + 1;
    localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_MS * 1000 * CLK_MHZ + 1;
    localparam int WAKE_FILT_CYC = WAKE_FILT_US * CLK_MHZ;
    // 20 kbaud bit is 50us, well inside the dominant timeout
    localparam int MAX_BAUD = 20000;
    localparam int TMR_W = 22;

    // ************************************************************
    // modes and fail-safe sources
    // ************************************************************
    typedef enum logic [1:0] {
        LINTC_FAILSAFE, LINTC_NORMAL, LINTC_SILENT, LINTC_SLEEP
    } lintc_mode_t;

    typedef enum logic [1:0] {
        LINTC_SRC_NONE, LINTC_SRC_BUS, LINTC_SRC_LOCAL, LINTC_SRC_BATT
    } lintc_src_t;
endpackage

//--- src/lintc_timer.sv
// saturating interval counter on the internal time base
// assumes synchronous clear and a held limit
`timescale 1ns/100ps
module lintc_timer import lintc_pkg::*; #(
    parameter int W = TMR_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // control
    lintc_tmr_if.tmr t
);
    logic [W-1:0] cnt_r;
    wire reached = (cnt_r >= t.limit[W-1:0]);

    // counting stops at the limit so done stays high
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (ce) begin
            if (t.clr || !t.run) begin
                cnt_r <= '0;
            end else if (!reached) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign t.done = reached && t.run && !t.clr;
endmodule // lintc_timer

//--- src/lintc_tmr_if.sv
// interface between the mode controller and its timer
// assumes one clock domain
`timescale 1ns/100ps
interface lintc_tmr_if;
    logic run;
    logic clr;
    logic [21:0] limit;
    logic done;
    modport ctl (output run, output clr, output limit, input done);
    modport tmr (input run, input clr, input limit, output done);
endinterface

//--- tb/lintc_bus_model.sv
// far side: wired bus with pull-up and the mcu transmit pin
// assumes the mcu lets go of its pin while the device drives it
`timescale 1ns/100ps
module lintc_bus_model (
    // device side
    input wire logic bus_drive_low,
    input wire logic txd_out,
    input wire logic txd_oe,
    // other nodes and mcu
    input wire logic node_low,
    input wire logic mcu_txd,
    // resolved lines
    output logic bus_level,
    output logic txd_pin
);
    // recessive unless any node pulls low
    assign bus_level = !(bus_drive_low || node_low);
    assign txd_pin = txd_oe ? txd_out : mcu_txd;
endmodule // lintc_bus_model

//--- tb/lintc_core_props.sv
// port-level checker for the lin transceiver mode control
// assumes ce held high by the bench
`timescale 1ns/100ps
module lintc_core_props import lintc_pkg::*; #(
    parameter int DOM_CYC = 200
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // pins and monitors
    input wire logic mode_sel,
    input wire logic txd_in,
    input wire logic rxd,
    input wire logic bus_in,
    input wire logic bus_drive_low,
    input wire logic battery_uv_tx,
    input wire logic vcc_uv,
    input wire logic driver_shutdown_temperature,
    input wire logic internal_reset_n,
    input wire logic [1:0] mode
);
    // ****
    // helper
    // ****
    // counts dominant cycles; one extra for the registered answer
    int unsigned dom_cnt_r;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) dom_cnt_r <= 0;
        else dom_cnt_r <= bus_drive_low ? dom_cnt_r + 1 : 0;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_uv_blocks_tx: assert property (
        battery_uv_tx |=> !bus_drive_low) else $error("driver on in uv");
    a_txd_high_off: assert property (
        txd_in |=> !bus_drive_low) else $error("driver on, txd high");
    a_hot_driver_off: assert property (
        driver_shutdown_temperature |=> !bus_drive_low)
        else $error("driver on while hot");
    a_vcc_uv_reset: assert property (
        vcc_uv |-> ##[1:2] !internal_reset_n) else $error("no reset");
    a_reset_to_failsafe: assert property (
        vcc_uv && mode != LINTC_SLEEP |-> ##[1:2] mode == LINTC_FAILSAFE)
        else $error("no fail-safe on uv");
    a_rx_mirror_bus: assert property (
        mode == LINTC_NORMAL && $past(mode) == LINTC_NORMAL
        |-> rxd == $past(bus_in)) else $error("rxd not bus");
    a_silent_entry: assert property (
        mode == LINTC_NORMAL && $fell(mode_sel) && txd_in && !vcc_uv
        |=> mode == LINTC_SILENT) else $error("no silent");
    a_sleep_entry: assert property (
        mode == LINTC_NORMAL && $fell(mode_sel) && !txd_in && !vcc_uv
        |=> mode == LINTC_SLEEP) else $error("no sleep");
    a_drive_in_normal: assert property (
        bus_drive_low |-> mode == LINTC_NORMAL || $past(mode) == LINTC_NORMAL)
        else $error("driver on outside normal");
    a_dom_timeout: assert property (
        dom_cnt_r <= DOM_CYC + 1) else $error("dominant too long");
    c_drive: cover property (bus_drive_low);
    c_silent: cover property (mode == LINTC_SILENT);
    c_sleep: cover property (mode == LINTC_SLEEP);
endmodule // lintc_core_props

bind lintc_core lintc_core_props #(.DOM_CYC(DOM_CYC)) u_props (
    .mclk(mclk), .rst_n(rst_n), .mode_sel(mode_sel), .txd_in(txd_in),
    .rxd(rxd), .bus_in(bus_in), .bus_drive_low(bus_drive_low),
    .battery_uv_tx(battery_uv_tx), .vcc_uv(vcc_uv),
    .driver_shutdown_temperature(driver_shutdown_temperature),
    .internal_reset_n(internal_reset_n), .mode(mode));

//--- tb/tb_lin_transceiver_control.sv
// self-checking bench for the lin transceiver mode control
// assumes shortened timeout and re-arm counts
`timescale 1ns/100ps
module tb_lin_transceiver_control;
    import lintc_pkg::*;
    localparam int DOM = 200;
    localparam int RA = 10;
    logic mclk = 0, rst_n = 0, mode_sel = 0, mcu_txd = 1, local_wake_n = 1;
    logic node_low = 0, uv_tx = 0, uv_fs = 0, vcc_uv = 0, hot = 0;
    logic txd_out, txd_oe, rxd, bus_drive_low, bus_level, txd_pin;
    logic rst_int_n, reg_en;
    logic [1:0] mode;
    int n_fail = 0;
    int n_compared = 0;
    always #4 mclk = ~mclk;
    lintc_core #(.DOM_CYC(DOM), .REARM(RA), .WAKE_CYC(8)) dut (
        .mclk(mclk), .rst_n(rst_n), .ce(1'h1), .mode_sel(mode_sel),
        .txd_in(txd_pin), .txd_out(txd_out), .txd_oe(txd_oe), .rxd(rxd),
        .local_wake_input(local_wake_n), .bus_in(bus_level),
        .bus_drive_low(bus_drive_low), .battery_uv_tx(uv_tx),
        .battery_uv_fs(uv_fs), .vcc_uv(vcc_uv),
        .driver_shutdown_temperature(hot), .internal_reset_n(rst_int_n),
        .regulator_en(reg_en), .mode(mode));
    lintc_bus_model u_bus (.bus_drive_low(bus_drive_low), .txd_out(txd_out),
        .txd_oe(txd_oe), .node_low(node_low), .mcu_txd(mcu_txd),
        .bus_level(bus_level), .txd_pin(txd_pin));
    // ****
    // helpers
    // ****
    // sample 1 ns after the edge so registered outputs have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_entry_txd_low;
        @(posedge mclk) {mcu_txd, mode_sel} <= 2'h1;
        cyc(4); chk(mode, LINTC_NORMAL);
        chk(bus_drive_low, 1'h0);
        @(posedge mclk) mcu_txd <= 1'h1;
        cyc(RA + 3); chk(bus_drive_low, 1'h0);
        @(posedge mclk) mcu_txd <= 1'h0;
        cyc(3); chk(bus_drive_low, 1'h1);
        chk(rxd, 1'h0);
    endtask
    task automatic t_timeout;
        cyc(DOM + 5); chk(bus_drive_low, 1'h0);
        chk(rxd, 1'h1);
        @(posedge mclk) mcu_txd <= 1'h1;
        cyc(RA + 3);
        @(posedge mclk) mcu_txd <= 1'h0;
        cyc(3); chk(bus_drive_low, 1'h1);
    endtask
    task automatic t_guards;
        @(posedge mclk) hot <= 1'h1;
        cyc(2); chk(bus_drive_low, 1'h0);
        chk(reg_en, 1'h1);
        chk(rxd, 1'h1);
        @(posedge mclk) hot <= 1'h0;
        cyc(2); chk(bus_drive_low, 1'h1);
        @(posedge mclk) uv_tx <= 1'h1;
        cyc(2); chk(bus_drive_low, 1'h0);
        @(posedge mclk) {uv_tx, mcu_txd} <= 2'h1;
    endtask
    task automatic t_batt_silent_wake;
        @(posedge mclk) uv_fs <= 1'h1;
        cyc(3); chk({txd_out, rxd}, 2'h2);
        chk(txd_oe, 1'h1);
        @(posedge mclk) {uv_fs, mode_sel} <= 2'h0;
        cyc(3); chk(mode, LINTC_SILENT);
        chk({reg_en, rxd}, 2'h3);
        @(posedge mclk) local_wake_n <= 1'h0;
        cyc(3); chk(mode, LINTC_FAILSAFE);
        chk({txd_out, rxd}, 2'h1);
        @(posedge mclk) {local_wake_n, mode_sel} <= 2'h3;
    endtask
    task automatic t_sleep_short;
        cyc(3); chk(mode, LINTC_NORMAL);
        @(posedge mclk) {mcu_txd, node_low} <= 2'h1;
        @(posedge mclk) mode_sel <= 1'h0;
        cyc(3); chk(mode, LINTC_SLEEP);
        chk(reg_en, 1'h0);
        cyc(20);
        @(posedge mclk) node_low <= 1'h0;
        cyc(5); chk(mode, LINTC_FAILSAFE);
        chk({txd_out, rxd}, 2'h0);
    endtask
    task automatic t_vcc;
        @(posedge mclk) {mcu_txd, mode_sel} <= 2'h3;
        cyc(3); chk(mode, LINTC_NORMAL);
        @(posedge mclk) mode_sel <= 1'h0;
        cyc(3); chk(mode, LINTC_SILENT);
        chk({reg_en, rxd}, 2'h3);
        @(posedge mclk) mode_sel <= 1'h1;
        cyc(3); chk(mode, LINTC_NORMAL);
        @(posedge mclk) vcc_uv <= 1'h1;
        cyc(3); chk(rst_int_n, 1'h0);
        chk(mode, LINTC_FAILSAFE);
        @(posedge mclk) vcc_uv <= 1'h0;
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'h1;
        cyc(4); chk(mode, LINTC_FAILSAFE);
        chk({bus_drive_low, reg_en}, 2'h1);
        t_entry_txd_low();
        t_timeout();
        t_guards();
        t_batt_silent_wake();
        t_sleep_short();
        t_vcc();
        cyc(4);
        final_report();
    end
    // the run needs under 600 cycles
    initial begin
        #(8 * 5000);
        n_fail++;
        final_report();
    end
endmodule // tb_lin_transceiver_control
